/* arsel_map.svh */
// register offsets, field positions, reset values and conversion lengths
// assumes a 32-bit APB bus, one aligned word per register, data in bits 7:0
`ifndef ARSEL_MAP_SVH
`define ARSEL_MAP_SVH

`define ARSEL_OFF_INSEL  12'h000
`define ARSEL_OFF_CTLB   12'h004
`define ARSEL_OFF_CTLA   12'h008
`define ARSEL_OFF_RESL   12'h00C
`define ARSEL_OFF_RESH   12'h010
`define ARSEL_OFF_IRQST  12'h014
`define ARSEL_OFF_IRQMSK 12'h018

`define ARSEL_BIT_LADJ   5
`define ARSEL_BIT_BIN    7
`define ARSEL_BIT_IPR    5
`define ARSEL_BIT_EN     7
`define ARSEL_BIT_START  6
`define ARSEL_BIT_DONE   0

`define ARSEL_RST_INSEL  8'h00
`define ARSEL_RST_RES    10'h000

`define ARSEL_CH_TEMP    4'hF
`define ARSEL_CYC_NORMAL 5'd13
`define ARSEL_CYC_LONG   5'd25

`endif

/* arsel_pkg.sv */
// types shared by the converter result and input select block
// assumes nothing beyond the companion map header
package arsel_pkg;

  typedef enum logic [2:0] {
    ARSEL_REF_SUPPLY     = 3'b000,
    ARSEL_REF_EXT        = 3'b001,
    ARSEL_REF_INT11      = 3'b010,
    ARSEL_REF_INT11_BYP  = 3'b011,
    ARSEL_REF_INT256     = 3'b110,
    ARSEL_REF_INT256_BYP = 3'b111
  } arsel_ref_t;

  typedef enum logic [0:0] {
    ARSEL_IDLE = 1'b0,
    ARSEL_CONV = 1'b1
  } arsel_state_t;

  typedef struct packed {
    logic [3:0] channel;
    logic       gain_20x;
    logic       temp_en;
    arsel_ref_t ref_src;
    logic       ref_pin_connect;
    logic       int_ref_on;
    logic       bipolar;
    logic       pol_rev;
    logic       sample;
  } arsel_afe_t;

endpackage

/* arsel_top.sv */
// converter digital side: input/reference select, result coding, APB registers
// assumes an analog front end that returns a signed code in 1024/vref units,
// gain already applied, sampled at the last converter clock of a conversion
//
// Overview of operation
// - single-ended result is unsigned 0 to 3FF
// - unipolar differential clamps negative difference to zero
// - reset gives unipolar; bipolar only when set
// - bipolar result is 512-scaled two's complement
// - bit 9 is sign in bipolar mode
// - channel 1111 selects temperature sensor input
// - reference field bits 7,6,4, deferred during conversion
// - reference change makes next conversion 25 cycles
// - reference field decode to supply, pin, internal
// - bit 5 left-adjusts result, applies immediately
// - channel field bits 3:0, deferred during conversion
// - codes 0-3 single-ended, 1100 bandgap, 1101 ground
// - codes 0100-1011 differential pairs, odd gain 20x
// - same input both sides gives offset measurement
// - low byte read locks result until high read
// - left/right adjusted byte placement of result
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "arsel_map.svh"

module arsel_top #(
  parameter int unsigned PRESCALE = 2  // system clocks per converter clock
) (
  input  wire logic              pclk,     // system clock
  input  wire logic              presetn,  // async reset, active low
  input  wire logic              ce,       // clock enable, freezes state when low
  input  wire logic              psel,     // apb select
  input  wire logic              penable,  // apb access phase
  input  wire logic              pwrite,   // apb write
  input  wire logic [11:0]       paddr,    // apb byte address
  input  wire logic [31:0]       pwdata,   // apb write data
  input  wire logic [3:0]        pstrb,    // apb byte strobes
  output logic [31:0]            prdata,   // apb read data
  output logic                   pready,   // apb ready
  output logic                   pslverr,  // apb error on unmapped address
  input  wire logic signed [11:0] afe_code, // front end code at conversion end
  output var arsel_pkg::arsel_afe_t afe_ctrl, // front end controls
  output logic                   irq       // level interrupt
);

  localparam logic [7:0] PRE_LAST = 8'(PRESCALE - 1);

  function automatic logic is_diff(input logic [3:0] ch);
    is_diff = (ch[3:2] == 2'b01) || (ch[3:2] == 2'b10);
  endfunction

  function automatic logic [9:0] encode(input logic signed [11:0] v, input logic bip);
    logic signed [11:0] h;
    h = v >>> 1;
    if (bip)
    begin
      if (h > 12'sh1FF) encode = 10'h1FF;
      else if (h < 12'shE00) encode = 10'h200;
      else encode = h[9:0];
    end
    else if (v < 12'sh000) encode = 10'h000;
    else if (v > 12'sh3FF) encode = 10'h3FF;
    else encode = v[9:0];
  endfunction

  function automatic logic [7:0] fmt(input logic [9:0] r, input logic ladj, input logic hi);
    if (ladj) fmt = hi ? r[9:2] : {r[1:0], 6'h00};
    else fmt = hi ? {6'h00, r[9:8]} : r[7:0];
  endfunction

  function automatic arsel_pkg::arsel_ref_t ref_decode(input logic [2:0] c);
    case (c)
      3'b001:  ref_decode = arsel_pkg::ARSEL_REF_EXT;
      3'b010:  ref_decode = arsel_pkg::ARSEL_REF_INT11;
      3'b011:  ref_decode = arsel_pkg::ARSEL_REF_INT11_BYP;
      3'b110:  ref_decode = arsel_pkg::ARSEL_REF_INT256;
      3'b111:  ref_decode = arsel_pkg::ARSEL_REF_INT256_BYP;
      default: ref_decode = arsel_pkg::ARSEL_REF_SUPPLY;
    endcase
  endfunction

  logic [7:0]  sel_q, sel_d;
  logic        bin_q, bin_d, ipr_q, ipr_d, en_q, en_d;
  logic        st_q, st_d, mask_q, mask_d, lock_q, lock_d;
  logic        dirty_q, dirty_d, first_q, first_d;
  logic        pready_d, pslverr_d, irq_d;
  logic [7:0]  rdat_d;
  logic [7:0]  rdat_q;
  arsel_pkg::arsel_state_t state_q, state_d;
  logic [7:0]  pre_q, pre_d;
  logic [4:0]  cyc_q, cyc_d;
  logic [6:0]  act_q, act_d;
  logic [9:0]  res_q, res_d;
  arsel_pkg::arsel_afe_t afe_d;

  logic xfer, wr, rd, start, done_evt, lock_eff;
  logic [2:0] ref_new, ref_cur;

  assign xfer     = psel & penable & pready;
  assign wr       = xfer & pwrite & pstrb[0];
  assign rd       = xfer & ~pwrite;
  assign ref_cur  = {sel_q[7], sel_q[6], sel_q[4]};
  assign ref_new  = {sel_d[7], sel_d[6], sel_d[4]};
  assign start    = wr && paddr == `ARSEL_OFF_CTLA && pwdata[`ARSEL_BIT_START] && en_d
                    && state_q == arsel_pkg::ARSEL_IDLE;
  assign done_evt = ce && state_q == arsel_pkg::ARSEL_CONV && en_q && pre_q == PRE_LAST && cyc_q == 5'd1;
  // a completing high-byte read releases the lock in the same cycle
  assign lock_eff = lock_q & ~(rd && paddr == `ARSEL_OFF_RESH);
  assign prdata   = {24'h000000, rdat_q};

  always_comb
  begin
    sel_d   = sel_q;
    bin_d   = bin_q;
    ipr_d   = ipr_q;
    en_d    = en_q;
    mask_d  = mask_q;
    lock_d  = lock_q;
    if (wr && paddr == `ARSEL_OFF_INSEL) sel_d = pwdata[7:0];
    if (wr && paddr == `ARSEL_OFF_CTLB)
    begin
      bin_d = pwdata[`ARSEL_BIT_BIN];
      ipr_d = pwdata[`ARSEL_BIT_IPR];
    end
    if (wr && paddr == `ARSEL_OFF_CTLA) en_d = pwdata[`ARSEL_BIT_EN];
    if (wr && paddr == `ARSEL_OFF_IRQMSK) mask_d = pwdata[`ARSEL_BIT_DONE];
    // completion beats a simultaneous write-one clear
    st_d = st_q & ~(wr && paddr == `ARSEL_OFF_IRQST && pwdata[`ARSEL_BIT_DONE]);
    if (done_evt) st_d = 1'b1;
    if (rd && paddr == `ARSEL_OFF_RESL) lock_d = 1'b1;
    if (rd && paddr == `ARSEL_OFF_RESH) lock_d = 1'b0;
    dirty_d = (dirty_q & ~start) | (ref_new != ref_cur);
    // enable and start in one write still count as the first conversion
    first_d = (first_q | (en_d & ~en_q)) & ~start;
    irq_d   = st_d & mask_d;
    // one wait state: answer registered the cycle after the access phase opens
    pready_d  = psel & penable & ~pready;
    pslverr_d = 1'b0;
    case (paddr)
      `ARSEL_OFF_INSEL:  rdat_d = sel_q;
      `ARSEL_OFF_CTLB:   rdat_d = {bin_q, 1'b0, ipr_q, 5'h00};
      `ARSEL_OFF_CTLA:   rdat_d = {en_q, state_q == arsel_pkg::ARSEL_CONV, 6'h00};
      `ARSEL_OFF_RESL:   rdat_d = fmt(res_q, sel_q[`ARSEL_BIT_LADJ], 1'b0);
      `ARSEL_OFF_RESH:   rdat_d = fmt(res_q, sel_q[`ARSEL_BIT_LADJ], 1'b1);
      `ARSEL_OFF_IRQST:  rdat_d = {7'h00, st_q};
      `ARSEL_OFF_IRQMSK: rdat_d = {7'h00, mask_q};
      default:
      begin
        rdat_d    = 8'h00;
        pslverr_d = pready_d;
      end
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    pre_d   = pre_q;
    cyc_d   = cyc_q;
    act_d   = act_q;
    res_d   = res_q;
    case (state_q)
      arsel_pkg::ARSEL_IDLE:
      begin
        if (start)
        begin
          state_d = arsel_pkg::ARSEL_CONV;
          pre_d   = 8'h00;
          // selection is latched here, so later writes wait for the next conversion
          act_d   = {ref_cur, sel_q[3:0]};
          cyc_d   = (dirty_q | first_q | (en_d & ~en_q)) ? `ARSEL_CYC_LONG : `ARSEL_CYC_NORMAL;
        end
      end
      arsel_pkg::ARSEL_CONV:
      begin
        if (!en_q) state_d = arsel_pkg::ARSEL_IDLE;
        else if (pre_q == PRE_LAST)
        begin
          pre_d = 8'h00;
          cyc_d = cyc_q - 5'd1;
          if (cyc_q == 5'd1)
          begin
            state_d = arsel_pkg::ARSEL_IDLE;
            // a locked result is dropped, not queued
            if (!lock_eff) res_d = encode(afe_code, bin_q & is_diff(act_q[3:0]));
          end
        end
        else pre_d = pre_q + 8'h01;
      end
      default: state_d = arsel_pkg::ARSEL_IDLE;
    endcase
    afe_d.channel         = act_q[3:0];
    afe_d.gain_20x        = is_diff(act_q[3:0]) & act_q[0];
    afe_d.temp_en         = act_q[3:0] == `ARSEL_CH_TEMP;
    afe_d.ref_src         = ref_decode(act_q[6:4]);
    afe_d.ref_pin_connect = act_q[6:4] == 3'b001 || act_q[6:4] == 3'b011 || act_q[6:4] == 3'b111;
    afe_d.int_ref_on      = act_q[5];
    afe_d.bipolar         = bin_q;
    afe_d.pol_rev         = ipr_q;
    afe_d.sample          = state_d == arsel_pkg::ARSEL_CONV;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q    <= `ARSEL_RST_INSEL;
      bin_q    <= 1'b0;
      ipr_q    <= 1'b0;
      en_q     <= 1'b0;
      st_q     <= 1'b0;
      mask_q   <= 1'b0;
      lock_q   <= 1'b0;
      dirty_q  <= 1'b0;
      first_q  <= 1'b0;
      irq      <= 1'b0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      rdat_q   <= 8'h00;
      state_q  <= arsel_pkg::ARSEL_IDLE;
      pre_q    <= 8'h00;
      cyc_q    <= 5'h00;
      act_q    <= 7'h00;
      res_q    <= `ARSEL_RST_RES;
      afe_ctrl <= '0;
    end
    else if (ce)
    begin
      sel_q    <= sel_d;
      bin_q    <= bin_d;
      ipr_q    <= ipr_d;
      en_q     <= en_d;
      st_q     <= st_d;
      mask_q   <= mask_d;
      lock_q   <= lock_d;
      dirty_q  <= dirty_d;
      first_q  <= first_d;
      irq      <= irq_d;
      pready   <= pready_d;
      pslverr  <= pslverr_d;
      rdat_q   <= rdat_d;
      state_q  <= state_d;
      pre_q    <= pre_d;
      cyc_q    <= cyc_d;
      act_q    <= act_d;
      res_q    <= res_d;
      afe_ctrl <= afe_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  single_clamp_a: assert property (done_evt && !lock_eff && !is_diff(act_q[3:0]) && afe_code < 12'sh000
    |=> res_q == 10'h000) else $error("single-ended negative input not coded as zero");
  uni_clamp_a: assert property (done_evt && !lock_eff && is_diff(act_q[3:0]) && !bin_q
    && afe_code < 12'sh000 |=> res_q == 10'h000) else $error("unipolar difference not clamped");
  uni_mode_a: assert property (ce && !bin_q |=> !afe_ctrl.bipolar)
    else $error("bipolar front end without bipolar bit");
  bip_top_a: assert property (done_evt && !lock_eff && is_diff(act_q[3:0]) && bin_q
    && afe_code > 12'sh400 |=> res_q == 10'h1FF) else $error("bipolar positive not saturated");
  bip_sign_a: assert property (done_evt && !lock_eff && is_diff(act_q[3:0]) && bin_q
    && afe_code < 12'shFFE |=> res_q[9]) else $error("bipolar sign bit missing");
  temp_sense_a: assert property (afe_ctrl.temp_en == (afe_ctrl.channel == `ARSEL_CH_TEMP))
    else $error("temperature sensor enable mismatch");
  sel_hold_a: assert property (ce && state_q == arsel_pkg::ARSEL_CONV && state_d == arsel_pkg::ARSEL_CONV
    |=> $stable(act_q)) else $error("selection changed during conversion");
  long_conv_a: assert property (ce && start && dirty_q |=> cyc_q == `ARSEL_CYC_LONG)
    else $error("reference change did not lengthen conversion");
  res_lock_a: assert property (done_evt && lock_eff |=> $stable(res_q))
    else $error("locked result was overwritten");
  ladj_read_a: assert property (ce && pready_d && !pwrite && paddr == `ARSEL_OFF_RESH
    && sel_q[`ARSEL_BIT_LADJ] |=> prdata[7:0] == $past(res_q[9:2])) else $error("left-adjusted high byte wrong");

endmodule
`default_nettype wire

/* arsel_top_bench.sv */
// bench for the converter select block: registers, result coding, timing, interrupt
// assumes arsel_top with PRESCALE 2; ce and pstrb are held active throughout
`timescale 1ns/1ps
`default_nettype none
`include "arsel_map.svh"

module arsel_top_bench;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [11:0]           paddr = 12'h000;
  logic [31:0]           pwdata = 32'h0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic signed [11:0]    afe_code = 12'h000;
  arsel_pkg::arsel_afe_t afe_ctrl;
  arsel_pkg::arsel_afe_t snap;
  logic                  irq;
  logic                  err;
  logic [7:0]            rd;
  logic [7:0]            lo;
  logic [7:0]            hi;
  int                    cyc = 0;
  int                    len;
  int                    n_errors = 0;
  int                    num_checks = 0;

  always #4 pclk = ~pclk;
  // latched selection is only meaningful while converting
  always @(posedge pclk)
  begin
    if (afe_ctrl.sample === 1'b1)
    begin
      cyc <= cyc + 1;
      snap <= afe_ctrl;
    end
  end

  arsel_top #(.PRESCALE(2)) u_arsel_top (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .afe_code(afe_code), .afe_ctrl(afe_ctrl), .irq(irq));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // pready and prdata are read at the rising edge, before that edge's update lands;
  // one idle cycle between calls keeps psel from being assigned twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      wrap_up();
    end
    else
    begin
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300)
    begin
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic conv(input logic [7:0] sel, input logic bip, input logic [11:0] code);
    int c0;
    afe_code <= code;
    apb(1'b1, `ARSEL_OFF_INSEL, sel);
    apb(1'b1, `ARSEL_OFF_CTLB, {bip, 7'h00});
    c0 = cyc;
    apb(1'b1, `ARSEL_OFF_CTLA, 8'hC0);
    wait_irq();
    len = cyc - c0;
    apb(1'b0, `ARSEL_OFF_RESL, 8'h00);
    lo = rd;
    apb(1'b0, `ARSEL_OFF_RESH, 8'h00);
    hi = rd;
    apb(1'b1, `ARSEL_OFF_IRQST, 8'h01);
  endtask

  task automatic t_reset();
    chk("afe after reset", 32'h0, {18'h0, afe_ctrl});
    apb(1'b0, `ARSEL_OFF_INSEL, 8'h00);
    chk("insel reset", 8'h00, rd);
    apb(1'b0, `ARSEL_OFF_CTLB, 8'h00);
    chk("bipolar reset", 1'b0, rd[7]);
    apb(1'b1, `ARSEL_OFF_CTLB, 8'h20);
    apb(1'b0, `ARSEL_OFF_CTLB, 8'h00);
    chk("polarity bit", 8'h20, rd);
    chk("polarity out", 1'b1, afe_ctrl.pol_rev);
    apb(1'b1, `ARSEL_OFF_CTLB, 8'h00);
    apb(1'b0, 12'h01C, 8'h00);
    chk("unmapped err", 1'b1, err);
    apb(1'b1, `ARSEL_OFF_IRQMSK, 8'h01);
  endtask

  task automatic t_single();
    conv(8'h00, 1'b0, 12'h155);
    chk("se code", 16'h0155, {hi, lo});
    chk("first conv long", 1'b1, len >= 44 && len <= 56);
    conv(8'h00, 1'b0, 12'h7FF);
    chk("se full scale", 16'h03FF, {hi, lo});
    chk("normal conv", 1'b1, len >= 22 && len <= 30);
    conv(8'h03, 1'b0, 12'hF80);
    chk("se ground", 16'h0000, {hi, lo});
    chk("se channel", 4'h3, snap.channel);
  endtask

  task automatic t_diff();
    conv(8'h06, 1'b0, 12'hFFB);
    chk("uni clamp", 16'h0000, {hi, lo});
    chk("gain 1x", 1'b0, snap.gain_20x);
    conv(8'h07, 1'b0, 12'h0C8);
    chk("uni diff", 16'h00C8, {hi, lo});
    chk("gain 20x", 1'b1, snap.gain_20x);
    conv(8'h05, 1'b0, 12'h010);
    chk("offset channel", 4'h5, snap.channel);
    conv(8'h0A, 1'b1, 12'hF00);
    chk("bip negative", 16'h0380, {hi, lo});
    chk("bipolar out", 1'b1, snap.bipolar);
    chk("sign set", 1'b1, hi[1]);
    conv(8'h0B, 1'b1, 12'h7FE);
    chk("bip clamp", 16'h01FF, {hi, lo});
    chk("sign clear", 1'b0, hi[1]);
  endtask

  task automatic t_ref();
    logic [2:0] r;
    for (int i = 0; i < 8; i++)
    begin
      r = i[2:0];
      conv({r[2], r[1], 1'b0, r[0], 4'h0}, 1'b0, 12'h001);
      chk("ref source", (r[2] && !r[1]) ? 3'b000 : r, snap.ref_src);
      chk("ref pin", r == 3'b001 || r == 3'b011 || r == 3'b111, snap.ref_pin_connect);
      chk("int ref on", r[1], snap.int_ref_on);
      if (i > 0)
        chk("ref change long", 1'b1, len >= 44 && len <= 56);
    end
    // temperature needs the 1.1V reference, selected together with the channel
    conv(8'h4F, 1'b0, 12'h13A);
    chk("temp enable", 1'b1, snap.temp_en);
    chk("temp channel", 4'hF, snap.channel);
    chk("temp ref", 3'b010, snap.ref_src);
  endtask

  task automatic t_align();
    conv(8'h00, 1'b0, 12'h2AB);
    chk("right adjust", 16'h02AB, {hi, lo});
    apb(1'b1, `ARSEL_OFF_INSEL, 8'h20);
    // low byte first so the high read releases the result lock
    apb(1'b0, `ARSEL_OFF_RESL, 8'h00);
    chk("left low", 8'hC0, rd);
    apb(1'b0, `ARSEL_OFF_RESH, 8'h00);
    chk("left high", 8'hAA, rd);
    apb(1'b1, `ARSEL_OFF_INSEL, 8'h00);
  endtask

  task automatic t_defer();
    afe_code <= 12'h011;
    apb(1'b1, `ARSEL_OFF_INSEL, 8'h01);
    apb(1'b1, `ARSEL_OFF_CTLA, 8'hC0);
    apb(1'b1, `ARSEL_OFF_INSEL, 8'h52);
    chk("channel held", 4'h1, afe_ctrl.channel);
    chk("ref held", 3'b000, afe_ctrl.ref_src);
    wait_irq();
    apb(1'b1, `ARSEL_OFF_IRQST, 8'h01);
    apb(1'b1, `ARSEL_OFF_CTLA, 8'hC0);
    wait_irq();
    chk("channel next", 4'h2, snap.channel);
    chk("ref next", 3'b011, snap.ref_src);
    apb(1'b1, `ARSEL_OFF_IRQST, 8'h01);
  endtask

  task automatic t_lock();
    conv(8'h00, 1'b0, 12'h123);
    afe_code <= 12'h0AA;
    apb(1'b0, `ARSEL_OFF_RESL, 8'h00);
    apb(1'b1, `ARSEL_OFF_CTLA, 8'hC0);
    wait_irq();
    apb(1'b0, `ARSEL_OFF_RESH, 8'h00);
    chk("locked high", 8'h01, rd);
    apb(1'b0, `ARSEL_OFF_RESL, 8'h00);
    chk("kept low", 8'h23, rd);
    apb(1'b1, `ARSEL_OFF_IRQST, 8'h01);
  endtask

  task automatic t_irq();
    int n;
    n = 0;
    apb(1'b1, `ARSEL_OFF_IRQMSK, 8'h00);
    apb(1'b1, `ARSEL_OFF_CTLA, 8'hC0);
    do
    begin
      apb(1'b0, `ARSEL_OFF_IRQST, 8'h00);
      n++;
    end
    while (rd[0] !== 1'b1 && n < 100);
    chk("done flag", 1'b1, rd[0]);
    chk("masked irq", 1'b0, irq);
    apb(1'b1, `ARSEL_OFF_IRQMSK, 8'h01);
    @(negedge pclk);
    chk("unmasked irq", 1'b1, irq);
    apb(1'b1, `ARSEL_OFF_IRQST, 8'h01);
    @(negedge pclk);
    chk("cleared irq", 1'b0, irq);
  endtask

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_single();
    t_diff();
    t_ref();
    t_align();
    t_defer();
    t_lock();
    t_irq();
    wrap_up();
  end
endmodule
`default_nettype wire
